// >>> logic/tbs_trigger_sorter.v
// trigger sequencer, comparator bin sorter and AHB-Lite register slave
`include "tbs_defs.vh"
`default_nettype none

module tbs_trigger_sorter (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// front panel
	input  wire        key_trig,
	input  wire        key_mode,
	output reg  [2:0]  mode_led,
	output reg  [2:0]  setting_page,
	input  wire        page_next,
	// trigger inputs
	input  wire        ext_trig,
	input  wire        handler_trig,
	input  wire        scanner_trig,
	// measurement engine
	input  wire [31:0] meas_value,
	input  wire [31:0] meas_secondary,
	input  wire        refresh_busy,
	output reg         meas_start,
	output reg         range_start,
	// handler port
	output reg         meas_done_n,
	output reg  [10:0] handler_bin,
	output reg         handler_valid
);

	localparam integer MEAS_CYC  = (`TBS_MEAS_NS + `TBS_CLK_NS - 1) / `TBS_CLK_NS;
	localparam integer RANGE_CYC = (`TBS_RANGE_NS + `TBS_CLK_NS - 1) / `TBS_CLK_NS;
	localparam integer UNIT_CYC  = (`TBS_DELAY_UNIT_NS + `TBS_CLK_NS - 1) / `TBS_CLK_NS;
	localparam [2:0] S_IDLE  = 3'd0;
	localparam [2:0] S_DELAY = 3'd1;
	localparam [2:0] S_RANGE = 3'd2;
	localparam [2:0] S_MEAS  = 3'd3;
	localparam [2:0] S_SORT  = 3'd4;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [31:0] ctrl_r;
	reg  [1:0]  mode_r;
	reg  [15:0] delay_r;
	reg  [31:0] nominal_r;
	reg  [31:0] sec_lo_r, sec_hi_r;
	reg  [31:0] bin_lo_r  [0:8], bin_hi_r [0:8];
	reg  [31:0] bin_cnt_r [0:10];
	reg  [31:0] result_r, result2_r;
	reg  [3:0]  verdict_r;
	reg  [2:0]  state_r;
	reg  [15:0] cyc_r, units_r;
	reg         bus_trig_r;
	reg         key_trig_q, key_mode_q, ext_q, hnd_q, scn_q;
	reg         ap_valid_r, ap_write_r;
	reg  [7:0]  ap_addr_r;
	integer     i, k;

	wire cmp_en  = ctrl_r[`TBS_F_CMP_EN];
	wire ap_take = hsel & htrans[1] & hready;
	// ----------------------------------------
	// functions
	// ----------------------------------------
	// a range with upper not above lower is off
	function in_range;
		input [31:0] v;
		input [31:0] lo;
		input [31:0] hi;
		begin
			in_range = ($signed(hi) > $signed(lo)) && ($signed(v) >= $signed(lo)) &&
				($signed(v) <= $signed(hi));
		end
	endfunction

	function [31:0] abs_lim;
		input [31:0] lim;
		input        tol;
		input [31:0] nom;
		begin
			abs_lim = tol ? nom + lim : lim;
		end
	endfunction

	// ----------------------------------------
	// trigger sources
	// ----------------------------------------
	wire key_trig_p = key_trig & ~key_trig_q;
	wire key_mode_p = key_mode & ~key_mode_q;
	wire ext_p = (ext_trig & ~ext_q) | (handler_trig & ~hnd_q) | (scanner_trig & ~scn_q);
	reg trig_req;
	always @* begin
		case (mode_r)
			`TBS_MODE_INT: trig_req = 1'b1;
			`TBS_MODE_MAN: trig_req = key_trig_p;
			`TBS_MODE_EXT: trig_req = ext_p;
			`TBS_MODE_BUS: trig_req = bus_trig_r;
			default:       trig_req = 1'b0;
		endcase
	end

	// only taken in idle: requests during a measurement are dropped outright;
	// refresh_busy does not block, so refresh time is open for triggers
	wire trig_acc = trig_req & (state_r == S_IDLE);
	// ----------------------------------------
	// sorting
	// ----------------------------------------
	reg [3:0] sort_v;
	reg       hit;
	always @* begin
		sort_v = `TBS_V_NOMATCH;
		hit = 1'b0;
		for (k = 0; k < `TBS_NBINS; k = k + 1) begin
			if (!hit && ctrl_r[`TBS_F_BIN_EN_LO + k] &&
				in_range(result_r, abs_lim(bin_lo_r[k], ctrl_r[`TBS_F_TOL], nominal_r),
				abs_lim(bin_hi_r[k], ctrl_r[`TBS_F_TOL], nominal_r))) begin
				sort_v = k[3:0] + 4'h1;
				hit = 1'b1;
			end
		end
		if (hit && ctrl_r[`TBS_F_SEC_EN] && !in_range(result2_r, sec_lo_r, sec_hi_r)) begin
			sort_v = `TBS_V_SECFAIL;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= S_IDLE;
			cyc_r <= 16'h0000;
			units_r <= 16'h0000;
			meas_done_n <= 1'b0;
			meas_start <= 1'b0;
			range_start <= 1'b0;
			result_r <= 32'h0000_0000;
			result2_r <= 32'h0000_0000;
			verdict_r <= `TBS_V_NONE;
			key_trig_q <= 1'b0;
			ext_q <= 1'b0;
			hnd_q <= 1'b0;
			scn_q <= 1'b0;
		end else begin
			key_trig_q <= key_trig;
			ext_q <= ext_trig;
			hnd_q <= handler_trig;
			scn_q <= scanner_trig;
			meas_start <= 1'b0;
			range_start <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (trig_acc) begin
						meas_done_n <= 1'b1;
						units_r <= delay_r;
						cyc_r <= 16'h0000;
						if (delay_r == 16'h0000) begin
							state_r <= ctrl_r[`TBS_F_AUTORNG] ? S_RANGE : S_MEAS;
							range_start <= ctrl_r[`TBS_F_AUTORNG];
							meas_start <= ~ctrl_r[`TBS_F_AUTORNG];
						end else begin
							state_r <= S_DELAY;
						end
					end
				end
				S_DELAY: begin
					if (cyc_r == UNIT_CYC[15:0] - 16'h1) begin
						cyc_r <= 16'h0000;
						units_r <= units_r - 16'h1;
						if (units_r == 16'h1) begin
							state_r <= ctrl_r[`TBS_F_AUTORNG] ? S_RANGE : S_MEAS;
							range_start <= ctrl_r[`TBS_F_AUTORNG];
							meas_start <= ~ctrl_r[`TBS_F_AUTORNG];
						end
					end else begin
						cyc_r <= cyc_r + 16'h1;
					end
				end
				S_RANGE: begin
					if (cyc_r == RANGE_CYC[15:0] - 16'h1) begin
						cyc_r <= 16'h0000;
						state_r <= S_MEAS;
						meas_start <= 1'b1;
					end else begin
						cyc_r <= cyc_r + 16'h1;
					end
				end
				S_MEAS: begin
					if (cyc_r == MEAS_CYC[15:0] - 16'h1) begin
						cyc_r <= 16'h0000;
						result_r <= meas_value;
						result2_r <= meas_secondary;
						state_r <= S_SORT;
					end else begin
						cyc_r <= cyc_r + 16'h1;
					end
				end
				S_SORT: begin
					verdict_r <= cmp_en ? sort_v : `TBS_V_NONE;
					meas_done_n <= 1'b0;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// handler port and front panel
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			handler_bin <= 11'h000;
			handler_valid <= 1'b0;
			mode_led <= 3'h1;
			setting_page <= 3'h0;
			key_mode_q <= 1'b0;
		end else begin
			key_mode_q <= key_mode;
			if (!cmp_en) begin
				handler_bin <= 11'h000;
				handler_valid <= 1'b0;
			end else if (state_r == S_SORT) begin
				handler_bin <= (sort_v == `TBS_V_NONE) ? 11'h000 :
					(11'h001 << (sort_v - 4'h1));
				handler_valid <= 1'b1;
			end else if (trig_acc) begin
				handler_valid <= 1'b0;
			end
			case (mode_r)
				`TBS_MODE_INT: mode_led <= 3'h1;
				`TBS_MODE_MAN: mode_led <= 3'h2;
				`TBS_MODE_EXT: mode_led <= 3'h4;
				default:       mode_led <= 3'h0;
			endcase
			if (ap_valid_r && ap_write_r && ap_addr_r == `TBS_A_CTRL &&
				hwdata[`TBS_F_CMP_EN] && !cmp_en) begin
				setting_page <= `TBS_PAGE_SORT;
			end else if (page_next) begin
				setting_page <= setting_page + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire        wr = ap_valid_r & ap_write_r;
	wire [3:0]  widx = ap_addr_r[5:2];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r <= 8'h00;
			ctrl_r <= `TBS_CTRL_RST;
			mode_r <= `TBS_MODE_INT;
			delay_r <= `TBS_DELAY_RST;
			nominal_r <= 32'h0000_0000;
			sec_lo_r <= 32'h0000_0000;
			sec_hi_r <= 32'h0000_0000;
			bus_trig_r <= 1'b0;
			for (i = 0; i < 9; i = i + 1) begin
				bin_lo_r[i] <= 32'h0000_0000;
				bin_hi_r[i] <= 32'h0000_0000;
			end
			for (i = 0; i < 11; i = i + 1) begin
				bin_cnt_r[i] <= 32'h0000_0000;
			end
		end else begin
			ap_valid_r <= ap_take;
			ap_write_r <= hwrite;
			ap_addr_r <= haddr[7:0];
			bus_trig_r <= 1'b0;
			if (key_mode_p) begin
				mode_r <= (mode_r == `TBS_MODE_MAN) ? `TBS_MODE_EXT :
					(mode_r == `TBS_MODE_INT) ? `TBS_MODE_MAN : `TBS_MODE_INT;
			end
			if (wr) begin
				if (ap_addr_r == `TBS_A_CTRL) ctrl_r <= hwdata;
				if (ap_addr_r == `TBS_A_DELAY) delay_r <= hwdata[15:0];
				if (ap_addr_r == `TBS_A_NOMINAL) nominal_r <= hwdata;
				if (ap_addr_r == `TBS_A_SEC_LO) sec_lo_r <= hwdata;
				if (ap_addr_r == `TBS_A_SEC_HI) sec_hi_r <= hwdata;
				if (ap_addr_r[7:6] == 2'b01 && widx < 4'd9) bin_lo_r[widx] <= hwdata;
				if (ap_addr_r[7:6] == 2'b10 && widx < 4'd9) bin_hi_r[widx] <= hwdata;
				if (ap_addr_r == `TBS_A_CMD) begin
					if (hwdata[`TBS_C_BUS_MODE]) mode_r <= `TBS_MODE_BUS;
					bus_trig_r <= hwdata[`TBS_C_BUS_TRIG];
				end
			end
			// count clear wins only if no part is being counted that cycle
			if (state_r == S_SORT && cmp_en && sort_v != `TBS_V_NONE) begin
				bin_cnt_r[sort_v - 4'h1] <= bin_cnt_r[sort_v - 4'h1] + 32'h1;
			end else if (wr && ap_addr_r == `TBS_A_CMD && hwdata[`TBS_C_CNT_CLR]) begin
				for (i = 0; i < 11; i = i + 1) begin
					bin_cnt_r[i] <= 32'h0000_0000;
				end
			end
		end
	end

	// read data from flops, captured in the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			hrdata <= 32'h0000_0000;
			case (haddr[7:0])
				`TBS_A_CTRL:    hrdata <= ctrl_r;
				`TBS_A_DELAY:   hrdata <= {16'h0000, delay_r};
				`TBS_A_NOMINAL: hrdata <= nominal_r;
				`TBS_A_STATUS:  hrdata <= {24'h000000, meas_done_n, state_r, 2'b00, mode_r};
				`TBS_A_RESULT:  hrdata <= result_r;
				`TBS_A_VERDICT: hrdata <= {28'h0000000, verdict_r};
				`TBS_A_SEC_LO:  hrdata <= sec_lo_r;
				`TBS_A_SEC_HI:  hrdata <= sec_hi_r;
				default: begin
					if (haddr[7:6] == 2'b01 && haddr[5:2] < 4'd9)
						hrdata <= bin_lo_r[haddr[5:2]];
					else if (haddr[7:6] == 2'b10 && haddr[5:2] < 4'd9)
						hrdata <= bin_hi_r[haddr[5:2]];
					else if (haddr[7:6] == 2'b11 && haddr[5:2] < 4'd11)
						hrdata <= bin_cnt_r[haddr[5:2]];
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> logic/tbs_defs.vh
// constants for the trigger and bin sorter: register map, fields, reset values, timing
`ifndef TBS_DEFS_VH
`define TBS_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TBS_A_CTRL      8'h00
`define TBS_A_CMD       8'h04
`define TBS_A_DELAY     8'h08
`define TBS_A_NOMINAL   8'h0C
`define TBS_A_STATUS    8'h10
`define TBS_A_RESULT    8'h14
`define TBS_A_VERDICT   8'h18
`define TBS_A_SEC_LO    8'h1C
`define TBS_A_SEC_HI    8'h20
`define TBS_A_BIN_LO    8'h40
`define TBS_A_BIN_HI    8'h80
`define TBS_A_COUNT     8'hC0

// ----------------------------------------
// control fields
// ----------------------------------------
`define TBS_F_MODE_LO   0
`define TBS_F_MODE_HI   1
`define TBS_F_CMP_EN    2
`define TBS_F_AUTORNG   3
`define TBS_F_TOL       4
`define TBS_F_SEC_EN    5
`define TBS_F_BIN_EN_LO 8
`define TBS_F_BIN_EN_HI 16

// command register bits
`define TBS_C_BUS_MODE  0
`define TBS_C_BUS_TRIG  1
`define TBS_C_CNT_CLR   2

// ----------------------------------------
// trigger modes and verdict codes
// ----------------------------------------
`define TBS_MODE_INT    2'h0
`define TBS_MODE_MAN    2'h1
`define TBS_MODE_EXT    2'h2
`define TBS_MODE_BUS    2'h3
`define TBS_NBINS       9
`define TBS_V_NONE      4'h0
`define TBS_V_NOMATCH   4'hA
`define TBS_V_SECFAIL   4'hB
`define TBS_PAGE_SORT   3'h6

// ----------------------------------------
// reset values
// ----------------------------------------
`define TBS_CTRL_RST    32'h0000_0000
`define TBS_DELAY_RST   16'h0000

// ----------------------------------------
// timing (ns) and clock
// ----------------------------------------
`define TBS_CLK_NS      50
`define TBS_MEAS_NS     2000
`define TBS_RANGE_NS    1000
`define TBS_DELAY_UNIT_NS 1000

`endif

// >>> verif/tbs_trigger_sorter_sva.sv
// assertions on the trigger and bin sorter ports
`default_nettype none
module tbs_trigger_sorter_sva (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// watched outputs
	input wire logic        meas_start,
	input wire logic        range_start,
	input wire logic        meas_done_n,
	input wire logic [10:0] handler_bin,
	input wire logic        handler_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [15:0] hi_r;
	// length of the current busy stretch; the length check needs at least 41 cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_r <= 16'h0000;
		end else begin
			hi_r <= meas_done_n ? hi_r + 16'h0001 : 16'h0000;
		end
	end
	AST_START_BUSY: assert property ((meas_start || range_start) |-> meas_done_n)
		else $error("start pulse outside busy window");
	AST_ONE_START: assert property (meas_start |=> !meas_start [*8])
		else $error("second start inside one measurement");
	AST_RANGE_FIRST: assert property (range_start |-> ##[19:21] meas_start)
		else $error("ranging not followed by measurement");
	AST_START_BOUND: assert property ($rose(meas_done_n) |-> ##[0:1000] (meas_start || range_start))
		else $error("no start after trigger acceptance");
	AST_DONE_LEN: assert property ($fell(meas_done_n) |-> hi_r >= 16'h0029)
		else $error("measurement shorter than 41 cycles");
	AST_VALID_AT_END: assert property ($rose(handler_valid) |-> $fell(meas_done_n))
		else $error("verdict not at end of measurement");
	AST_VALID_DROPS: assert property ($rose(meas_done_n) |-> !handler_valid)
		else $error("old verdict kept past new trigger");
	AST_BIN_ONEHOT: assert property (handler_valid |-> $onehot(handler_bin))
		else $error("handler bins not one-hot");
	COV_RANGE: cover property (range_start);
	COV_NOMATCH: cover property ($rose(handler_valid) && handler_bin[9]);
	COV_DONE: cover property ($fell(meas_done_n));
endmodule
bind tbs_trigger_sorter tbs_trigger_sorter_sva u_sva (.hclk, .hresetn, .meas_start,
	.range_start, .meas_done_n, .handler_bin, .handler_valid);
`default_nettype wire

// >>> verif/tbs_handler_model.sv
// handler model: fires its trigger line once a part is placed and the meter is idle
`default_nettype none
module tbs_handler_model (
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// handler side
	input wire logic       place,
	input wire logic [3:0] gap,
	input wire logic       meas_done_n,
	output var logic       handler_trig
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_r;
	logic       armed_r;
	// waits for meas_done_n low, so a real handler never double-triggers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_r <= 1'b0;
			wait_r <= 4'h0;
			handler_trig <= 1'b0;
		end else begin
			handler_trig <= 1'b0;
			if (place) begin
				armed_r <= 1'b1;
				wait_r <= gap;
			end else if (armed_r && !meas_done_n) begin
				if (wait_r == 4'h0) begin
					handler_trig <= 1'b1;
					armed_r <= 1'b0;
				end else begin
					wait_r <= wait_r - 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/tbs_trigger_sorter_tb.sv
// self-checking bench for the trigger and bin sorter
`include "tbs_defs.vh"
`default_nettype none
module tbs_trigger_sorter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, meas_value = 0, rdv, meas_sec = 0;
	logic [2:0]  trig = 0, mode_led, setting_page;
	logic        key_mode = 0, refresh_busy = 0, place = 0, handler_trig, valid_q = 0;
	logic [3:0]  gap = 0, code;
	logic        meas_start, range_start, meas_done_n, handler_valid;
	logic [10:0] handler_bin;
	logic [3:0]  q[$];
	int          miscompares = 0, samples_checked = 0, seed = 26, starts = 0, ends = 0;
	int          hi_cnt = 0, last_len = 0, cnt1 = 0, i, r;
	logic [31:0] v;

	always #25 hclk = ~hclk;

	tbs_trigger_sorter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_trig(trig[2]),
		.key_mode(key_mode), .mode_led(mode_led), .setting_page(setting_page), .page_next(1'b0),
		.ext_trig(trig[0]), .handler_trig(handler_trig), .scanner_trig(trig[1]),
		.meas_value(meas_value), .meas_secondary(meas_sec), .refresh_busy(refresh_busy),
		.meas_start(meas_start), .range_start(range_start), .meas_done_n(meas_done_n),
		.handler_bin(handler_bin), .handler_valid(handler_valid));

	tbs_handler_model u_handler (.hclk(hclk), .hresetn(hresetn), .place(place), .gap(gap),
		.meas_done_n(meas_done_n), .handler_trig(handler_trig));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic hang(input int n);
		if (n >= 4000) begin
			miscompares++;
			tally_and_finish;
		end
	endtask

	// one single-word transfer, address phase then data phase, each held until hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		hsel <= 1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 4000);
		hang(n);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 4000);
		hang(n);
		rdv = hrdata;
	endtask

	task automatic pulse(input int b);
		trig[b] <= 1;
		tick(1);
		trig[b] <= 0;
	endtask

	task automatic press;
		key_mode <= 1;
		tick(2);
		key_mode <= 0;
		tick(3);
	endtask

	task automatic idle;
		int n;
		for (n = 0; n < 4000 && meas_done_n !== 1'b0; n++) tick(1);
		hang(n);
		tick(2);
	endtask

	// kind: 0 ext, 1 scanner, 2 key, 3 bus command, 4 handler; code 0 expects no verdict
	task automatic run(input int kind, input logic [31:0] val, input logic [3:0] c, input int len);
		int n, s0, e0;
		meas_value <= val;
		refresh_busy <= 1'($random(seed));
		if (c != 0) q.push_back(c);
		s0 = starts;
		e0 = ends;
		if (kind == 3) bus(1, `TBS_A_CMD, 32'h0000_0003);
		else if (kind == 4) begin
			place <= 1;
			gap <= 4'($random(seed));
			tick(1);
			place <= 0;
		end else pulse(kind);
		if (kind == 0) begin
			tick(5);
			pulse(0);
		end
		for (n = 0; n < 4000 && ends == e0; n++) tick(1);
		hang(n);
		tick(1);
		chk("meas_len", last_len, len);
		chk("starts", starts - s0, 1);
		if (c != 0) begin
			bus(0, `TBS_A_VERDICT, 0);
			chk("verdict", rdv, {28'h000_0000, c});
			bus(0, `TBS_A_RESULT, 0);
			chk("result", rdv, val);
			if (c == 4'h1) cnt1++;
		end
	endtask

	task automatic pick;
		r = $unsigned($random(seed)) % 3;
		v = r == 0 ? 110 + $unsigned($random(seed)) % 30 : r == 1 ? 300 : 500 + r * 77;
		code = r == 0 ? 4'h1 : r == 1 ? 4'h3 : `TBS_V_NOMATCH;
	endtask

	always @(posedge hclk) begin
		if (meas_start === 1'b1) starts++;
		if (meas_done_n === 1'b1) hi_cnt++;
		else if (hi_cnt > 0) begin
			last_len = hi_cnt;
			hi_cnt = 0;
			ends++;
		end
		if (handler_valid === 1'b1 && valid_q !== 1'b1) begin
			if (q.size() == 0) chk("verdict queue", 0, 1);
			else chk("handler_bin", {21'h0, handler_bin}, 32'h1 << (q.pop_front() - 1));
		end
		valid_q = handler_valid;
	end

	initial begin
		tick(8);
		hresetn <= 1;
		tick(1);
		bus(0, `TBS_A_CTRL, 0);
		chk("ctrl reset", rdv, `TBS_CTRL_RST);
		bus(0, `TBS_A_DELAY, 0);
		chk("delay reset", rdv, 32'h0000_0000);
		bus(0, 8'h24, 0);
		chk("unmapped", rdv, 32'h0000_0000);
		chk("hresp", hresp, 0);
		chk("led int", mode_led, 3'h1);
		idle;
		chk("int len", last_len, 41);
		press;
		chk("led man", mode_led, 3'h2);
		idle;
		bus(1, `TBS_A_BIN_LO, 100);
		bus(1, `TBS_A_BIN_HI, 200);
		bus(1, `TBS_A_BIN_LO + 4, 300);
		bus(1, `TBS_A_BIN_HI + 4, 300);
		bus(1, `TBS_A_BIN_LO + 8, 150);
		bus(1, `TBS_A_BIN_HI + 8, 400);
		bus(1, `TBS_A_CMD, 32'h0000_0004);
		bus(1, `TBS_A_CTRL, 32'h0000_0704);
		tick(2);
		chk("page", setting_page, `TBS_PAGE_SORT);
		for (i = 0; i < 3; i++) begin
			pick;
			run(2, v, code, 41);
		end
		press;
		chk("led ext", mode_led, 3'h4);
		for (i = 0; i < 9; i++) begin
			pick;
			run(i % 3 == 2 ? 4 : i % 3, v, code, 41);
		end
		bus(1, `TBS_A_DELAY, 1);
		bus(1, `TBS_A_CTRL, 32'h0000_070C);
		run(0, 120, 4'h1, 81);
		bus(1, `TBS_A_DELAY, 0);
		bus(1, `TBS_A_NOMINAL, 1000);
		bus(1, `TBS_A_CTRL, 32'h0000_0714);
		run(1, 1150, 4'h1, 41);
		bus(0, `TBS_A_COUNT, 0);
		chk("count bin1", rdv, cnt1);
		// secondary range checked only after a primary hit
		bus(1, `TBS_A_SEC_LO, 10);
		bus(1, `TBS_A_SEC_HI, 20);
		bus(1, `TBS_A_CTRL, 32'h0000_0734);
		run(1, 1150, `TBS_V_SECFAIL, 41);
		meas_sec <= 15;
		run(0, 1300, 4'h3, 41);
		bus(1, `TBS_A_CMD, 32'h0000_0001);
		tick(2);
		chk("led bus", mode_led, 3'h0);
		run(3, 1300, 4'h3, 41);
		bus(1, `TBS_A_CTRL, 32'h0000_0000);
		run(3, 120, 4'h0, 41);
		chk("gated bins", {handler_valid, handler_bin}, 0);
		press;
		chk("led wrap", mode_led, 3'h1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
